/* pdf_pkg.sv */
// Package for the periodic descriptor field decoder.
// Assumes descriptors arrive as 32-bit dwords in the controller core clock domain.
package pdf_pkg;
  // First dword field positions
  localparam int EP_LOW_BIT = 31;
  localparam int MULT_HI = 30;
  localparam int MULT_LO = 29;
  localparam int MAXP_HI = 28;
  localparam int MAXP_LO = 18;
  localparam int LEN_HI = 17;
  localparam int LEN_LO = 3;
  localparam int VALID_BIT = 0;
  // Limits
  localparam logic [10:0] MAXP_ISO_LIMIT = 11'h400;
  localparam logic [14:0] LEN_LIMIT = 15'h7fff;
  // Interrupt descriptor: fifth dword mask and result fields, count width and microframes
  localparam int MASK_W = 8;
  localparam int RES_W = 3;
  localparam int RES_BASE = 8;
  localparam int CNT_W = 12;
  localparam int UFRAMES = 8;
  // Execution states
  typedef enum logic [3:0] {
    PDF_IDLE = 4'b0001,
    PDF_RUN = 4'b0010,
    PDF_DONE = 4'b0100,
    PDF_FAIL = 4'b1000
  } pdf_state_t;
endpackage : pdf_pkg

/* pdf_fields_if.sv */
// Interface carrying decoded first-dword fields to the execution logic.
// Assumes one core clock domain.
`timescale 1ns/1ps
interface pdf_fields_if;
  logic ep_low; // Endpoint low bit
  logic [1:0] mult; // Packet multiplier
  logic [10:0] maxp; // Max packet bytes
  logic [14:0] len; // Bytes to move
  logic valid; // Descriptor active
  logic maxp_ok; // Max packet within isochronous limit
  modport src (output ep_low, mult, maxp, len, valid, maxp_ok);
  modport dst (input ep_low, mult, maxp, len, valid, maxp_ok);
endinterface : pdf_fields_if

/* pdf_dw0_decode.sv */
// Decoder for the first descriptor dword.
// Assumes dword is stable while it is decoded; purely combinational.
`timescale 1ns/1ps
module pdf_dw0_decode (
  input wire logic [31:0] dw0,
  pdf_fields_if.src f
);
  assign f.ep_low = dw0[pdf_pkg::EP_LOW_BIT];
  assign f.mult = dw0[pdf_pkg::MULT_HI:pdf_pkg::MULT_LO];
  assign f.maxp = dw0[pdf_pkg::MAXP_HI:pdf_pkg::MAXP_LO];
  assign f.len = dw0[pdf_pkg::LEN_HI:pdf_pkg::LEN_LO];
  assign f.valid = dw0[pdf_pkg::VALID_BIT];
  // Bits 2..1 are never looked at
  assign f.maxp_ok = (f.maxp <= pdf_pkg::MAXP_ISO_LIMIT);
endmodule : pdf_dw0_decode

/* pdf_periodic_fields.sv */
// Contract
// - Endpoint low bit taken from bit 31
// - Bits 30:29 give back-to-back packet count
// - Bits 28:18 max packet, up to 1024
// - Bits 17:3 total length, below 32 kB
// - Clear valid on completion or fatal error
// - Fifth dword: eight results and mask
// - Dwords six to eight pack counts
//
// Top of the periodic descriptor field block: decodes the first dword,
// tracks execution, writes back the cleared valid bit, and packs the
// interrupt descriptor status and count dwords.
// Assumes the transaction engine reports each packet and any fatal error.
// Assumes the mask is presented with load; a load while busy only refreshes it.
// Limitation: a dword offered while busy is dropped, so software must wait.
`timescale 1ns/1ps
module pdf_periodic_fields #(
  parameter int UF = 8 // Microframes per frame
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic load, // Pulse: dw0 and dw1 are presented
  input wire logic [31:0] dw0, // First descriptor dword
  input wire logic [2:0] ep_high, // Upper endpoint bits from second dword
  input wire logic pkt_done, // Pulse: one packet finished
  input wire logic [10:0] pkt_bytes, // Bytes in that packet
  input wire logic fatal_err, // Pulse: fatal error
  input wire logic [7:0] uf_mask_in, // Scheduled microframes
  input wire logic uf_rec, // Pulse: record a microframe result
  input wire logic [2:0] uf_sel, // Which microframe
  input wire logic [2:0] uf_result, // Result code
  input wire logic [11:0] uf_count, // Bytes received
  output logic [3:0] endpoint_number, // Full endpoint address
  output logic [1:0] packet_multiplier,
  output logic [10:0] max_packet_bytes,
  output logic [14:0] bytes_to_move,
  output logic busy, // Executing
  output logic bad_maxp, // Max packet above limit
  output logic issue_ok, // Another packet may be issued now
  output logic [14:0] bytes_moved, // Running byte total
  output logic wb_strobe, // Pulse: write back dword 0
  output logic [31:0] wb_dw0, // Dword 0 with valid cleared
  output logic [31:0] dw4_out, // Fifth interrupt dword
  output logic [31:0] dw5_out,
  output logic [31:0] dw6_out,
  output logic [31:0] dw7_out
);
  pdf_fields_if f ();
  pdf_pkg::pdf_state_t state_reg, state_next;
  logic [31:0] dw0_reg; // Latched descriptor dword
  logic [1:0] pkt_cnt_reg; // Packets issued this execution
  logic [14:0] moved_reg;
  logic [2:0] res_reg [UF]; // Per-microframe result
  logic [11:0] cnt_reg [UF]; // Per-microframe received bytes
  logic [7:0] mask_reg;
  logic [95:0] cnt_flat;

  pdf_dw0_decode u_dec (
    .dw0(dw0_reg),
    .f(f)
  );

  // Decoded outputs held in dw0_reg come from flip-flops; the upper endpoint bits come live from ep_high
  assign endpoint_number = {ep_high, f.ep_low};
  assign packet_multiplier = f.mult;
  assign max_packet_bytes = f.maxp;
  assign bytes_to_move = f.len;
  assign bad_maxp = ~f.maxp_ok;
  assign busy = (state_reg == pdf_pkg::PDF_RUN);
  assign bytes_moved = moved_reg;

  // Named decodes of the state register and the event pulses
  wire in_idle = (state_reg == pdf_pkg::PDF_IDLE); // Free to take a descriptor
  wire take_load = load && in_idle; // Dword accepted into the latch
  wire start_run = take_load && dw0[pdf_pkg::VALID_BIT]; // Only an active dword starts work
  // Either exit path of a run
  wire ending = (state_next == pdf_pkg::PDF_DONE) || (state_next == pdf_pkg::PDF_FAIL);
  wire count_pkt = busy && pkt_done; // Packet belongs to this execution
  wire desc_live = f.valid; // Latched valid bit, high for the whole run
  wire rec_hit = uf_rec && mask_reg[uf_sel]; // Unscheduled microframes record nothing
  // Sum one bit wider, so the carry shows an overflow instead of wrapping
  wire [15:0] sum_wide = {5'h00, pkt_bytes} + {1'b0, moved_reg};
  wire [14:0] moved_sum = sum_wide[15] ? pdf_pkg::LEN_LIMIT : sum_wide[14:0];
  wire [2:0] cnt_plus = {1'b0, pkt_cnt_reg} + 3'h1; // Packets issued including this one
  // Last packet: multiplier count reached or the length used up
  wire last_pkt = pkt_done && ((cnt_plus >= {1'b0, f.mult})
    || (sum_wide >= {1'b0, f.len}));

  // Multiplier zero still lets one packet through; a zero field is malformed
  assign issue_ok = busy && desc_live
    && (pkt_cnt_reg < f.mult || (f.mult == 2'h0 && pkt_cnt_reg == 2'h0))
    && (moved_reg < f.len);

  // Next-state logic; fatal error wins over completion
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      pdf_pkg::PDF_IDLE:
      begin
        // Only a valid descriptor starts work; software owns that bit
        if (start_run)
          state_next = pdf_pkg::PDF_RUN;
      end
      pdf_pkg::PDF_RUN:
      begin
        if (fatal_err)
          state_next = pdf_pkg::PDF_FAIL;
        else if (last_pkt)
          state_next = pdf_pkg::PDF_DONE;
      end
      pdf_pkg::PDF_DONE:
      begin
        // One cycle in which the write-back strobe stands
        state_next = pdf_pkg::PDF_IDLE;
      end
      pdf_pkg::PDF_FAIL:
      begin
        // Aborted run leaves the same way as a finished one
        state_next = pdf_pkg::PDF_IDLE;
      end
      default:
      begin
        // Stray code from an upset falls back to idle
        state_next = pdf_pkg::PDF_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state_reg <= pdf_pkg::PDF_IDLE;
    else
      state_reg <= state_next;
  end

  // Descriptor latch, cleared valid on both exit paths
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      dw0_reg <= 32'h0;
    else if (take_load)
      dw0_reg <= dw0;
    else if (ending)
      dw0_reg[pdf_pkg::VALID_BIT] <= 1'b0;
  end

  // Packet and byte counters
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pkt_cnt_reg <= 2'h0;
      moved_reg <= 15'h0;
    end
    else if (take_load)
    begin
      pkt_cnt_reg <= 2'h0;
      moved_reg <= 15'h0;
    end
    else if (count_pkt)
    begin
      pkt_cnt_reg <= pkt_cnt_reg + 2'h1;
      // Saturate at the field limit rather than wrap
      moved_reg <= moved_sum;
    end
  end

  // Write-back pulse in the cycle the cleared valid bit first shows
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      wb_strobe <= 1'b0;
    else
      wb_strobe <= ending;
  end
  assign wb_dw0 = dw0_reg;

  // Interrupt descriptor per-microframe store
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mask_reg <= 8'h0;
      for (int i = 0; i < UF; i++)
      begin
        res_reg[i] <= 3'h0;
        cnt_reg[i] <= 12'h0;
      end
    end
    else
    begin
      if (load)
        mask_reg <= uf_mask_in;
      // Only scheduled microframes record anything
      if (rec_hit)
      begin
        res_reg[uf_sel] <= uf_result;
        cnt_reg[uf_sel] <= uf_count;
      end
    end
  end

  // Pack results above the mask in the fifth dword
  always_comb
  begin
    dw4_out = 32'h0;
    dw4_out[pdf_pkg::MASK_W-1:0] = mask_reg;
    for (int i = 0; i < UF; i++)
      dw4_out[pdf_pkg::RES_BASE + i*pdf_pkg::RES_W +: pdf_pkg::RES_W] = res_reg[i];
  end

  // Counts run contiguous across dwords six to eight, some split
  always_comb
  begin
    cnt_flat = 96'h0;
    for (int i = 0; i < UF; i++)
      cnt_flat[i*pdf_pkg::CNT_W +: pdf_pkg::CNT_W] = cnt_reg[i];
  end
  assign dw5_out = cnt_flat[31:0];
  assign dw6_out = cnt_flat[63:32];
  assign dw7_out = cnt_flat[95:64];
  // Count 2 straddles dwords six and seven, count 5 straddles seven and eight;
  // packing from one flat vector keeps both splits right without special cases.
  // Limitation: the flat vector and the dword split assume eight microframes.
endmodule : pdf_periodic_fields

/* pdf_checker.sv */
// Concurrent checks on the periodic descriptor field block.
// Assumes it is bound to pdf_periodic_fields and sees its ports only.
`timescale 1ns/1ps
module pdf_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [31:0] dw0,
  input wire logic [2:0] ep_high,
  input wire logic fatal_err,
  input wire logic [7:0] uf_mask_in,
  input logic [3:0] endpoint_number,
  input logic [1:0] packet_multiplier,
  input logic [10:0] max_packet_bytes,
  input logic [14:0] bytes_to_move,
  input logic busy,
  input logic bad_maxp,
  input logic wb_strobe,
  input logic [31:0] wb_dw0,
  input logic [31:0] dw4_out
);
  // One domain, so one clock and reset for all
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_ep_high_live: assert property (endpoint_number[3:1] == ep_high)
    else $error("endpoint high bits wrong");
  a_ep_low_latch: assert property ($rose(busy) |-> endpoint_number[0] == $past(dw0[31]))
    else $error("endpoint low bit wrong");
  a_run_start: assert property ($rose(busy) |-> $past(load) && $past(dw0[0]))
    else $error("run began without a valid load");
  a_fields_latch: assert property ($rose(busy) |-> packet_multiplier == $past(dw0[30:29])
    && max_packet_bytes == $past(dw0[28:18]) && bytes_to_move == $past(dw0[17:3]))
    else $error("latched fields wrong");
  a_maxp_limit: assert property (bad_maxp == (max_packet_bytes > 11'h400))
    else $error("max packet flag wrong");
  a_fatal_end: assert property (busy && fatal_err |=> !busy && !wb_dw0[0])
    else $error("fatal error did not end run");
  a_wb_pulse: assert property ($fell(busy) |-> wb_strobe ##1 !wb_strobe)
    else $error("write back pulse wrong");
  a_wb_cleared: assert property (wb_strobe |-> !wb_dw0[0])
    else $error("written back valid bit set");
  a_mask_load: assert property (load |=> dw4_out[7:0] == $past(uf_mask_in))
    else $error("microframe mask not latched");
endmodule : pdf_checker
bind pdf_periodic_fields pdf_checker u_chk (.clk, .rst, .load, .dw0, .ep_high, .fatal_err,
  .uf_mask_in, .endpoint_number, .packet_multiplier, .max_packet_bytes, .bytes_to_move, .busy,
  .bad_maxp, .wb_strobe, .wb_dw0, .dw4_out);

/* pdf_periodic_fields_tb.sv */
// Self-checking bench for the periodic descriptor field block.
// Assumes the checker file is compiled alongside; drives all ports itself.
`timescale 1ns/1ps
module pdf_periodic_fields_tb;
  logic clk = 1'h0, rst = 1'h1, load = 1'h0, pkt_done = 1'h0, fatal_err = 1'h0, uf_rec = 1'h0;
  logic [31:0] dw0 = 32'h0, wb_dw0, dw4_out, dw5_out, dw6_out, dw7_out, d;
  logic [2:0] ep_high = 3'h0, uf_sel = 3'h0, uf_result = 3'h0;
  logic [10:0] pkt_bytes = 11'h0, max_packet_bytes;
  logic [7:0] uf_mask_in = 8'h0;
  logic [11:0] uf_count = 12'h0;
  logic [3:0] endpoint_number;
  logic [1:0] packet_multiplier;
  logic [14:0] bytes_to_move, bytes_moved;
  logic busy, bad_maxp, issue_ok, wb_strobe;
  logic [127:0] exp_st;
  logic [2:0] res_m [8] = '{default: 3'h0};
  logic [11:0] cnt_m [8] = '{default: 12'h0};
  integer seed = 45, mismatches = 0, n_checks = 0;
  pdf_periodic_fields #(.UF(8)) DUT (.clk, .rst, .load, .dw0, .ep_high, .pkt_done, .pkt_bytes,
    .fatal_err, .uf_mask_in, .uf_rec, .uf_sel, .uf_result, .uf_count, .endpoint_number,
    .packet_multiplier, .max_packet_bytes, .bytes_to_move, .busy, .bad_maxp, .issue_ok,
    .bytes_moved, .wb_strobe, .wb_dw0, .dw4_out, .dw5_out, .dw6_out, .dw7_out);
  // 100 MHz clock
  always #5 clk = ~clk;
  task automatic step;
    @(posedge clk);
    #1;
  endtask : step
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  // Expected status dwords four to seven from the recorded results
  function automatic logic [127:0] packed_status(input logic [7:0] m);
    logic [127:0] v;
    v = 128'h0;
    v[7:0] = m;
    for (int i = 0; i < 8; i++)
    begin
      v[8 + 3 * i +: 3] = res_m[i];
      v[32 + 12 * i +: 12] = cnt_m[i];
    end
    return v;
  endfunction : packed_status
  // One descriptor: load, packets until done or aborted at packet fat
  task automatic run(input logic [31:0] dv, input int fat);
    int lim;
    logic [15:0] tot;
    logic fin;
    load = 1'h1;
    dw0 = dv;
    ep_high = 3'($random(seed));
    step;
    load = 1'h0;
    check("busy", busy, dv[0]);
    check("ep", endpoint_number, {ep_high, dv[31]});
    check("mult", packet_multiplier, dv[30:29]);
    check("maxp", max_packet_bytes, dv[28:18]);
    check("badmaxp", bad_maxp, dv[28:18] > 11'h400);
    check("len", bytes_to_move, dv[17:3]);
    if (!dv[0])
      return;
    check("issue", issue_ok, 1'h1);
    lim = (dv[30:29] == 2'h0) ? 1 : dv[30:29];
    tot = 16'h0;
    fin = 1'h0;
    for (int k = 1; !fin; k++)
    begin
      pkt_bytes = 11'($random(seed));
      fatal_err = (k == fat);
      pkt_done = (k != fat);
      step;
      pkt_done = 1'h0;
      fatal_err = 1'h0;
      if (k != fat)
        tot = tot + pkt_bytes;
      fin = (k == fat) || (k >= lim) || (tot >= dv[17:3]);
      check("busy", busy, !fin);
      check("issue", issue_ok, !fin);
    end
    check("moved", bytes_moved, (tot > 16'h7fff) ? 15'h7fff : tot[14:0]);
    check("wbdw", wb_dw0, {dv[31:1], 1'h0});
    check("strobe", wb_strobe, 1'h1);
    step;
    check("strobe", wb_strobe, 1'h0);
    step;
    $display("descriptor %h done", dv);
  endtask : run
  initial
  begin
    repeat (2) @(posedge clk);
    #1 rst = 1'h0;
    check("dw4", dw4_out, 32'h0);
    // Load of an inactive dword starts no run but still latches the mask
    uf_mask_in = 8'($random(seed));
    run({31'($random(seed)), 1'h0}, 0);
    for (int i = 0; i < 8; i++)
    begin
      uf_rec = 1'h1;
      uf_sel = 3'(i);
      uf_result = 3'($random(seed));
      uf_count = 12'($random(seed));
      if (uf_mask_in[i])
      begin
        res_m[i] = uf_result;
        cnt_m[i] = uf_count;
      end
      step;
    end
    uf_rec = 1'h0;
    step;
    exp_st = packed_status(uf_mask_in);
    check("dw4", dw4_out, exp_st[31:0]);
    check("dw5", dw5_out, exp_st[63:32]);
    check("dw6", dw6_out, exp_st[95:64]);
    check("dw7", dw7_out, exp_st[127:96]);
    $display("status packing done");
    // Corners: top length, reserved bits set, over-limit size, abort
    run({1'h1, 2'h0, 11'h400, 15'h7fff, 2'h3, 1'h1}, 0);
    run({1'h0, 2'h3, 11'h401, 15'h0001, 2'h0, 1'h1}, 0);
    run({1'h1, 2'h3, 11'h7ff, 15'h7fff, 2'h0, 1'h1}, 2);
    for (int n = 0; n < 40; n++)
    begin
      d = $random(seed);
      d[0] = 1'h1; // Descriptor active
      d[3] = (d[17:4] == 14'h0) ? 1'h1 : d[3];
      run(d, (n % 3 == 0) ? 1 + n % 2 : 0);
    end
    wrap_up;
  end
  // Hang guard, well past the expected run length
  initial
  begin
    #200000;
    mismatches++;
    wrap_up;
  end
endmodule : pdf_periodic_fields_tb
